// ===== logic/nfc_pkg.sv
// Shared constants and types for the host-side NAND flash command sequencer.
// Assumes a 125 MHz system clock and an 8-bit multiplexed flash bus outside.
package nfc_pkg;

  // Clock rate and bus timing in nanoseconds, converted to cycles (rounded up)
  localparam int CLK_MHZ   = 125;
  localparam int T_WP_NS   = 12;   // Write strobe low time
  localparam int T_WH_NS   = 10;   // Write strobe high time
  localparam int T_REA_NS  = 20;   // Output strobe low to data valid
  localparam int T_WB_NS   = 100;  // Strobe edge to busy asserted
  localparam int T_WHR_NS  = 60;   // Command to first data read
  localparam int WP_CYC    = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WH_CYC    = (T_WH_NS * CLK_MHZ + 999) / 1000;
  localparam int REA_CYC   = (T_REA_NS * CLK_MHZ + 999) / 1000;
  localparam int WB_CYC    = (T_WB_NS * CLK_MHZ + 999) / 1000;
  localparam int WHR_CYC   = (T_WHR_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC  = 4;    // Extra low time covering the input synchroniser

  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WP_CNT     = CNT_W'(WP_CYC);
  localparam logic [CNT_W-1:0] WH_CNT     = CNT_W'(WH_CYC);
  localparam logic [CNT_W-1:0] RD_LOW_CNT = CNT_W'(REA_CYC + SYNC_CYC);
  localparam logic [CNT_W-1:0] WB_CNT     = CNT_W'(WB_CYC);
  localparam logic [CNT_W-1:0] WHR_CNT    = CNT_W'(WHR_CYC);

  // Command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONF  = 8'h30;
  localparam logic [7:0] CMD_COPY_CONF  = 8'h3a;
  localparam logic [7:0] CMD_COLRD      = 8'h05;
  localparam logic [7:0] CMD_COLRD_CONF = 8'he0;
  localparam logic [7:0] CMD_CACHE_RD   = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
  localparam logic [7:0] CMD_MULTI_RD   = 8'h60;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_COPY_SETUP = 8'h8c;
  localparam logic [7:0] CMD_COLWR      = 8'h85;
  localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
  localparam logic [7:0] CMD_CACHE_CONF = 8'h15;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_STATUS_MP  = 8'h71;
  localparam logic [7:0] CMD_RESET      = 8'hff;

  // Address byte indices: two column bytes then three row bytes
  localparam logic [2:0] IDX_COL0 = 3'h0;
  localparam logic [2:0] IDX_COL1 = 3'h1;
  localparam logic [2:0] IDX_ROW0 = 3'h2;
  localparam logic [2:0] IDX_ROW2 = 3'h4;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_CREAD = 4'h1, OP_CLAST = 4'h2, OP_MREAD = 4'h3,
    OP_COLRD = 4'h4, OP_PROG = 4'h5, OP_CPROG = 4'h6, OP_COLWR = 4'h7,
    OP_CPYRD = 4'h8, OP_CPYPG = 4'h9, OP_STATUS = 4'ha, OP_STATUS_MP = 4'hb,
    OP_RESET = 4'hc
  } nfc_op_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_NEXT = 6'h02, ST_WCYC = 6'h04,
    ST_RCYC = 6'h08, ST_GAP = 6'h10, ST_BUSY = 6'h20
  } nfc_state_t;

  typedef enum logic [8:0] {
    PH_SETUP = 9'h001, PH_ADDR = 9'h002, PH_SETUP2 = 9'h004, PH_DATA = 9'h008,
    PH_CONF = 9'h010, PH_TWB = 9'h020, PH_TWHR = 9'h040, PH_READ = 9'h080,
    PH_FIN = 9'h100
  } nfc_phase_t;

  typedef struct packed {
    logic [11:0] col;    // Column within the page
    logic [5:0]  page;   // Page within the block
    logic [10:0] block;  // Block; bit 0 selects the district
  } nfc_addr_t;

  typedef struct packed {
    nfc_op_t     op;
    nfc_addr_t   addr_a;  // Main address
    nfc_addr_t   addr_b;  // Second district for a multi-district read
    logic [11:0] len;     // Bytes to move
    logic        last;    // Issue the confirm of a program sequence
  } nfc_req_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       re_n;
    logic       lock_n;   // Program lock, low blocks program and erase
    logic [7:0] io_out;
    logic       io_oe_n;  // Low while the bus is driven
  } nfc_pin_t;

  // Byte i of the five-cycle address sequence
  function automatic logic [7:0] addr_byte(input nfc_addr_t a, input logic [2:0] i);
    logic [16:0] row;
    row = {a.block, a.page};
    case (i)
      3'h0:    addr_byte = a.col[7:0];
      3'h1:    addr_byte = {4'h0, a.col[11:8]};
      3'h2:    addr_byte = row[7:0];
      3'h3:    addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  endfunction : addr_byte

endpackage : nfc_pkg

// ===== logic/nfc_host.sv
// Host-side NAND flash sequencer with a write-data FIFO in front of the bus.
// Assumes the flash strobes and I/O sit on pins; io and ready/busy are async.
`timescale 1ns/1ns

// Simple synchronous FIFO; full and empty come from wrap-bit pointers
module nfc_fifo
  import nfc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,      // System clock
  input  wire logic             sys_rst,    // Synchronous reset, high
  input  wire logic             in_valid,   // Write request
  output logic                  in_ready,   // Space available
  input  wire logic [WIDTH-1:0] in_data,    // Write data
  output logic                  out_valid,  // Data available
  input  wire logic             out_ready,  // Read request
  output logic      [WIDTH-1:0] out_data    // Head of queue
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wptr_reg, wptr_next;
  logic [AW:0]      rptr_reg, rptr_next;
  logic             push, pop;

  // Pointer arithmetic; the extra bit tells full from empty
  always_comb begin
    in_ready  = (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]) || (wptr_reg[AW] == rptr_reg[AW]);
    out_valid = (wptr_reg != rptr_reg);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
    out_data  = mem_reg[rptr_reg[AW-1:0]];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule : nfc_fifo

module nfc_host
  import nfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       clock,        // 125 MHz system clock
  input  wire logic       sys_rst,      // Synchronous reset, high
  input  wire logic       req_valid,    // Operation request
  output logic            req_ready,    // Sequencer idle, request taken
  input  nfc_req_t        req,          // Operation, addresses, length
  input  wire logic       wr_valid,     // Program data offered
  output logic            wr_ready,     // FIFO has room
  input  wire logic [7:0] wr_data,      // Program data byte
  output logic            rd_valid,     // Read byte waiting
  input  wire logic       rd_ready,     // Read byte consumed
  output logic      [7:0] rd_data,      // Read byte
  output logic            done,         // Operation finished, one cycle
  output logic            err,          // Request refused, one cycle
  input  wire logic       prog_enable,  // Allow program and erase
  output nfc_pin_t        pins,         // Flash control pins and bus drive
  input  wire logic [7:0] io_in,        // Flash I/O bus as seen on the pins
  input  wire logic       rb_n_in       // Flash ready/busy pin, low busy
);
  nfc_state_t  st_reg,   st_next;
  nfc_phase_t  ph_reg,   ph_next;
  nfc_req_t    req_reg,  req_next;
  nfc_pin_t    pin_reg,  pin_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [11:0] len_reg,  len_next;
  logic [2:0]  idx_reg,  idx_next;
  logic        hi_reg,   hi_next;
  logic        grp_reg,  grp_next;
  logic        seq_reg,  seq_next;
  logic        rdv_reg,  rdv_next;
  logic [7:0]  rdd_reg,  rdd_next;
  logic        done_reg, done_next;
  logic        err_reg,  err_next;
  logic        rb_reg,   rb_next;
  logic [7:0]  io_s1, io_s2, io_s3;
  logic        rb_s1, rb_s2, rb_s3;
  logic        fifo_valid, fifo_pop;
  logic [7:0]  fifo_data;
  logic        bad_req;
  logic [2:0]  last_idx;
  logic [7:0]  setup_code, conf_code;
  logic        is_prog;
  nfc_addr_t   cur_addr;

  // Program data queue; a slow source stalls the data phase, not the bus timing
  nfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Pin synchronisers; only the second and third stages are looked at
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      io_s3 <= 8'h00;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
      rb_s3 <= 1'b1;
    end else begin
      io_s1 <= io_in;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      rb_s1 <= rb_n_in;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
    end
  end

  // Operation decode: command codes and address span per operation
  always_comb begin
    is_prog  = (req_reg.op == OP_PROG) || (req_reg.op == OP_CPROG) ||
               (req_reg.op == OP_COLWR) || (req_reg.op == OP_CPYPG);
    last_idx = ((req_reg.op == OP_COLRD) || (req_reg.op == OP_COLWR)) ? IDX_COL1 : IDX_ROW2;
    cur_addr = grp_reg ? req_reg.addr_b : req_reg.addr_a;
    case (req_reg.op)
      OP_CREAD:     setup_code = CMD_CACHE_RD;
      OP_CLAST:     setup_code = CMD_CACHE_LAST;
      OP_MREAD:     setup_code = CMD_MULTI_RD;
      OP_COLRD:     setup_code = CMD_COLRD;
      OP_PROG:      setup_code = CMD_PROG_SETUP;
      OP_CPROG:     setup_code = CMD_PROG_SETUP;
      OP_COLWR:     setup_code = CMD_COLWR;
      OP_CPYPG:     setup_code = CMD_COPY_SETUP;
      OP_STATUS:    setup_code = CMD_STATUS;
      OP_STATUS_MP: setup_code = CMD_STATUS_MP;
      OP_RESET:     setup_code = CMD_RESET;
      default:      setup_code = CMD_READ_SETUP;
    endcase
    case (req_reg.op)
      OP_COLRD: conf_code = CMD_COLRD_CONF;
      OP_CPYRD: conf_code = CMD_COPY_CONF;
      OP_CPROG: conf_code = CMD_CACHE_CONF;
      OP_CPYPG: conf_code = req_reg.last ? CMD_PROG_CONF : CMD_CACHE_CONF;
      OP_PROG:  conf_code = CMD_PROG_CONF;
      OP_COLWR: conf_code = CMD_PROG_CONF;
      default:  conf_code = CMD_READ_CONF;
    endcase
    // Multi-district pair must straddle both districts on one page
    bad_req = ((req.op == OP_MREAD) &&
               ((req.addr_a.block[0] == req.addr_b.block[0]) ||
                (req.addr_a.page != req.addr_b.page))) ||
              (((req.op == OP_CREAD) || (req.op == OP_CLAST)) && !seq_reg);
  end

  // Sequencer: walks the phases of one operation, one bus cycle at a time
  always_comb begin
    st_next   = st_reg;
    ph_next   = ph_reg;
    req_next  = req_reg;
    pin_next  = pin_reg;
    cnt_next  = cnt_reg;
    len_next  = len_reg;
    idx_next  = idx_reg;
    hi_next   = hi_reg;
    grp_next  = grp_reg;
    seq_next  = seq_reg;
    rdv_next  = rdv_reg;
    rdd_next  = rdd_reg;
    done_next = 1'b0;
    err_next  = 1'b0;
    fifo_pop  = 1'b0;
    rb_next   = (rb_s2 == rb_s3) ? rb_s3 : rb_reg;   // Counts once two stages agree
    if (rdv_reg && rd_ready) begin
      rdv_next = 1'b0;
    end
    // Lock stays released for the whole multi-district read
    pin_next.lock_n = ((st_reg != ST_IDLE) && (req_reg.op == OP_MREAD)) ? 1'b1
                      : prog_enable;
    case (st_reg)
      ST_IDLE: begin
        pin_next.ce_n    = 1'b1;
        pin_next.io_oe_n = 1'b1;
        if (req_valid) begin
          if (bad_req) begin
            err_next = 1'b1;
          end else begin
            req_next      = req;
            st_next       = ST_NEXT;
            ph_next       = PH_SETUP;
            grp_next      = 1'b0;
            len_next      = ((req.op == OP_STATUS) || (req.op == OP_STATUS_MP)) ? 12'h001 : req.len;
            pin_next.ce_n = 1'b0;
          end
        end
      end
      ST_NEXT: begin
        cnt_next = '0;
        hi_next  = 1'b0;
        case (ph_reg)
          PH_SETUP: begin
            st_next  = ST_WCYC;
            pin_next = '{cle: 1'b1, ale: 1'b0, ce_n: 1'b0, we_n: 1'b0, re_n: 1'b1,
                         lock_n: pin_next.lock_n, io_out: setup_code, io_oe_n: 1'b0};
            idx_next = (req_reg.op == OP_MREAD) ? IDX_ROW0 : IDX_COL0;
            case (req_reg.op)
              OP_CREAD, OP_CLAST, OP_RESET: ph_next = PH_TWB;
              OP_STATUS, OP_STATUS_MP:      ph_next = PH_TWHR;
              default:                      ph_next = PH_ADDR;
            endcase
          end
          PH_SETUP2: begin
            st_next  = ST_WCYC;
            pin_next = '{cle: 1'b1, ale: 1'b0, ce_n: 1'b0, we_n: 1'b0, re_n: 1'b1,
                         lock_n: pin_next.lock_n, io_out: CMD_MULTI_RD, io_oe_n: 1'b0};
            grp_next = 1'b1;
            idx_next = IDX_ROW0;
            ph_next  = PH_ADDR;
          end
          PH_ADDR: begin
            st_next  = ST_WCYC;
            pin_next = '{cle: 1'b0, ale: 1'b1, ce_n: 1'b0, we_n: 1'b0, re_n: 1'b1,
                         lock_n: pin_next.lock_n, io_out: addr_byte(cur_addr, idx_reg),
                         io_oe_n: 1'b0};
            idx_next = idx_reg + 3'h1;
            if (idx_reg == last_idx) begin
              if ((req_reg.op == OP_MREAD) && !grp_reg) begin
                ph_next = PH_SETUP2;
              end else if (is_prog) begin
                ph_next = PH_DATA;
              end else begin
                ph_next = PH_CONF;
              end
            end
          end
          PH_DATA: begin
            if (len_reg == 12'h000) begin
              // Without the confirm a later column change may refill the page
              ph_next = (req_reg.last || (req_reg.op == OP_CPYPG)) ? PH_CONF : PH_FIN;
            end else if (fifo_valid) begin
              fifo_pop = 1'b1;
              len_next = len_reg - 12'h001;
              st_next  = ST_WCYC;
              pin_next = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b0, we_n: 1'b0, re_n: 1'b1,
                           lock_n: pin_next.lock_n, io_out: fifo_data, io_oe_n: 1'b0};
            end
          end
          PH_CONF: begin
            st_next  = ST_WCYC;
            pin_next = '{cle: 1'b1, ale: 1'b0, ce_n: 1'b0, we_n: 1'b0, re_n: 1'b1,
                         lock_n: pin_next.lock_n, io_out: conf_code, io_oe_n: 1'b0};
            ph_next  = (req_reg.op == OP_COLRD) ? PH_TWHR : PH_TWB;
          end
          PH_TWB, PH_TWHR: begin
            st_next = ST_GAP;
          end
          PH_READ: begin
            if (len_reg == 12'h000) begin
              ph_next = PH_FIN;
            end else if (!rdv_reg) begin
              st_next       = ST_RCYC;
              pin_next.re_n = 1'b0;
            end
          end
          default: begin
            done_next     = 1'b1;
            st_next       = ST_IDLE;
            pin_next.ce_n = 1'b1;
            // A cached sequence is only valid after a plain or cached read; status reads keep it
            if ((req_reg.op == OP_READ) || (req_reg.op == OP_CREAD)) begin
              seq_next = 1'b1;
            end else if ((req_reg.op != OP_STATUS) && (req_reg.op != OP_STATUS_MP)) begin
              seq_next = 1'b0;
            end
          end
        endcase
      end
      ST_WCYC: begin
        cnt_next = cnt_reg + 1'b1;
        if (!hi_reg && (cnt_reg == WP_CNT - 1'b1)) begin
          hi_next       = 1'b1;
          cnt_next      = '0;
          pin_next.we_n = 1'b1;
        end else if (hi_reg && (cnt_reg == WH_CNT - 1'b1)) begin
          st_next          = ST_NEXT;
          pin_next.cle     = 1'b0;
          pin_next.ale     = 1'b0;
          pin_next.io_oe_n = 1'b1;
        end
      end
      ST_RCYC: begin
        if (!hi_reg) begin
          if (cnt_reg < RD_LOW_CNT - 1'b1) begin
            cnt_next = cnt_reg + 1'b1;
          end else if (io_s2 == io_s3) begin
            rdd_next      = io_s3;
            rdv_next      = 1'b1;
            len_next      = len_reg - 12'h001;
            pin_next.re_n = 1'b1;
            hi_next       = 1'b1;
            cnt_next      = '0;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == WH_CNT - 1'b1) begin
            st_next = ST_NEXT;
          end
        end
      end
      ST_GAP: begin
        cnt_next = cnt_reg + 1'b1;
        if ((ph_reg == PH_TWB) && (cnt_reg == WB_CNT - 1'b1)) begin
          st_next = ST_BUSY;
        end else if ((ph_reg == PH_TWHR) && (cnt_reg == WHR_CNT - 1'b1)) begin
          st_next = ST_NEXT;
          ph_next = PH_READ;
        end
      end
      default: begin
        // Strobes idle high while busy; no command is issued until ready
        if (rb_reg) begin
          st_next = ST_NEXT;
          ph_next = (is_prog || (req_reg.op == OP_MREAD) || (req_reg.op == OP_RESET))
                    ? PH_FIN : PH_READ;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg   <= ST_IDLE;
      ph_reg   <= PH_SETUP;
      req_reg  <= '0;
      pin_reg  <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1,
                    lock_n: 1'b0, io_out: 8'h00, io_oe_n: 1'b1};
      cnt_reg  <= '0;
      len_reg  <= 12'h000;
      idx_reg  <= 3'h0;
      hi_reg   <= 1'b0;
      grp_reg  <= 1'b0;
      seq_reg  <= 1'b0;
      rdv_reg  <= 1'b0;
      rdd_reg  <= 8'h00;
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
      rb_reg   <= 1'b1;
    end else begin
      st_reg   <= st_next;
      ph_reg   <= ph_next;
      req_reg  <= req_next;
      pin_reg  <= pin_next;
      cnt_reg  <= cnt_next;
      len_reg  <= len_next;
      idx_reg  <= idx_next;
      hi_reg   <= hi_next;
      grp_reg  <= grp_next;
      seq_reg  <= seq_next;
      rdv_reg  <= rdv_next;
      rdd_reg  <= rdd_next;
      done_reg <= done_next;
      err_reg  <= err_next;
      rb_reg   <= rb_next;
    end
  end

  // Outputs; req_ready decoded from the state, everything else straight from flops
  assign req_ready = (st_reg == ST_IDLE);
  assign rd_valid  = rdv_reg;
  assign rd_data   = rdd_reg;
  assign done      = done_reg;
  assign err       = err_reg;
  assign pins      = pin_reg;

endmodule : nfc_host

// ===== test/nfc_flash_model.sv
// Behavioural flash device answering the host sequencer's pins.
// Assumes one chip; a read byte is column plus row low byte.
`timescale 1ns/1ns
module nfc_flash_model
  import nfc_pkg::*;
(
  input  wire nfc_pin_t p,    // Host pins
  output logic    [7:0] io,   // Bus level at the host
  output logic          rb_n  // Ready/busy, low busy
);
  int          busy_ns = 800, n_prog = 0, sum = 0, na = 0, k;
  logic [7:0]  cmd = 8'h00, dout = 8'h00;  // Setup latched at power-on
  logic [11:0] col = 12'h000;
  logic [16:0] row = 17'h00000;
  event        go;
  // A released bus shows the inverse of the last byte, so a stale read cannot pass
  assign io = !p.io_oe_n ? p.io_out : (!p.re_n ? dout : ~dout);
  // Fixed busy time per array operation, verify loop included
  initial rb_n = 1'b1;
  always @(go) begin
    rb_n = 1'b0;
    #(busy_ns) rb_n = 1'b1;
  end
  // One byte per falling read strobe, column counts up
  always @(negedge p.re_n) if (!p.ce_n) begin
    dout = (cmd inside {8'h70, 8'h71}) ? {p.lock_n, rb_n, rb_n, 5'h00} : col[7:0] + row[7:0];
    col = col + 12'h001;
  end
  // Cycles latch on the rising write strobe
  always @(posedge p.we_n) if (!p.ce_n) begin
    if (p.cle && (rb_n || p.io_out inside {8'h70, 8'h71, 8'hff})) begin
      cmd = p.io_out;
      na = 0;
      if (cmd inside {8'h31, 8'h3f}) begin // Next page into the cache
        row = row + 17'h00001;
        col = 12'h000;
      end
      if (cmd inside {8'h10, 8'h15}) n_prog += p.lock_n;
      if (cmd inside {8'h30, 8'h3a, 8'h31, 8'h3f, 8'h10, 8'h15, 8'hff}) ->go;
    end else if (p.ale) begin // Column bytes, then row bytes
      k = na + ((cmd == 8'h60) ? 2 : 0);
      case (k)
        0: col[7:0] = p.io_out;
        1: col[11:8] = p.io_out[3:0];
        2: row[7:0] = p.io_out;
        3: row[15:8] = p.io_out;
        default: row[16] = p.io_out[0];
      endcase
      na++;
    end else if (!p.cle) sum += p.io_out;
  end
endmodule : nfc_flash_model

// ===== test/nfc_host_properties.sv
// Checker on the host sequencer's ports.
// Assumes it is bound to nfc_host; one clock domain.
`timescale 1ns/1ns
module nfc_host_properties
  import nfc_pkg::*;
(
  input wire logic       clock,       // Clock
  input wire logic       sys_rst,     // Reset
  input wire logic       rd_valid,    // Byte waiting
  input wire logic       rd_ready,    // Byte taken
  input wire logic [7:0] rd_data,     // Read byte
  input wire logic       done,        // Op end
  input wire logic       prog_enable, // Lock control
  input wire nfc_pin_t   pins,        // Flash pins
  input wire logic       rb_n_in      // Busy pin
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // A write strobe is two cycles low, then at least two high
  sequence s_we; !pins.we_n [*2] ##1 pins.we_n [*2]; endsequence
  property p_we; $fell(pins.we_n) |-> s_we; endproperty
  a_we: assert property (p_we) else $error("write strobe shape");
  property p_latch; $rose(pins.we_n) |-> $stable(pins.io_out) && !pins.io_oe_n; endproperty
  a_latch: assert property (p_latch) else $error("bus moved at latch");
  property p_idle; pins.ce_n |-> pins.we_n && pins.re_n && pins.io_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("strobe while deselected");
  property p_rd; !pins.re_n |-> pins.we_n && !pins.cle && !pins.ale && pins.io_oe_n; endproperty
  a_rd: assert property (p_rd) else $error("bad output cycle");
  property p_quiet; !pins.ce_n && !rb_n_in [*4] |-> pins.we_n && pins.re_n; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe while busy");
  property p_lock; !prog_enable [*2] |-> !pins.lock_n; endproperty
  a_lock: assert property (p_lock) else $error("lock not applied");
  property p_done; done |-> rb_n_in && $past(rb_n_in, 2); endproperty
  a_done: assert property (p_done) else $error("done while busy");
  property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read byte lost");
endmodule : nfc_host_properties
bind nfc_host nfc_host_properties chk_u (.clock(clock), .sys_rst(sys_rst), .rd_valid(rd_valid),
  .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .prog_enable(prog_enable), .pins(pins),
  .rb_n_in(rb_n_in));

// ===== test/nfc_host_bench.sv
// Self-checking bench: host sequencer against the behavioural flash.
// Assumes the model's row, sum and program count are visible by hierarchy.
`timescale 1ns/1ns
module nfc_host_bench
  import nfc_pkg::*;
;
  localparam logic [16:0] RA = {11'h2a5, 6'h05};
  logic       clock = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, wr_valid = 1'b0, e, f;
  logic       rd_ready = 1'b0, prog_enable = 1'b1, req_ready, wr_ready, rd_valid, done, err;
  logic [7:0] wr_data = 8'h00, rd_data, io_in, got [$];
  logic       rb_n_in;
  nfc_req_t   req = '0, r;
  nfc_pin_t   pins;
  int         n_fail = 0, n_compared = 0, cyc = 0;
  nfc_host dut_u (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .err(err), .prog_enable(prog_enable),
    .pins(pins), .io_in(io_in), .rb_n_in(rb_n_in));
  nfc_flash_model fm_u (.p(pins), .io(io_in), .rb_n(rb_n_in));
  // Clock; the consumer stalls every other cycle
  always #4 clock = ~clock;
  always @(posedge clock) rd_ready <= ~rd_ready;
  // Hang guard far above the longest run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  function automatic nfc_req_t mk(nfc_op_t o, logic [16:0] rw, logic [11:0] c, logic [11:0] n);
    mk = '0;
    mk.op = o;
    mk.addr_a = {c, rw[5:0], rw[16:6]};
    mk.len = n;
    mk.last = 1'b1;
  endfunction : mk
  // One request; gather bytes until done or err and the read port is empty
  task automatic run(input nfc_req_t q);
    int k;
    got.delete();
    {e, f} = 2'b00;
    @(posedge clock);
    req <= q;
    req_valid <= 1'b1;
    do @(negedge clock); while (req_ready !== 1'b1);
    @(posedge clock) req_valid <= 1'b0;
    for (k = 0; k < 5000 && !(f && rd_valid !== 1'b1); k++) begin
      @(negedge clock);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
      if (done === 1'b1 || err === 1'b1) f = 1'b1;
      if (err === 1'b1) e = 1'b1;
    end
    chk(f, 1'b1);
  endtask : run
  task automatic bytes_chk(input logic [7:0] b, input int n);
    chk(got.size(), n);
    foreach (got[k]) chk(got[k], b + 8'(k));
  endtask : bytes_chk
  // Page read, then cached pages, then a column jump in the last one
  task automatic t_read();
    run(mk(OP_CREAD, RA, 12'h000, 12'h002));
    chk(e, 1'b1);
    run(mk(OP_READ, RA, 12'h123, 12'h003));
    chk(fm_u.row, RA);
    bytes_chk(8'h23 + RA[7:0], 3);
    run(mk(OP_CREAD, RA, 12'h000, 12'h002));
    bytes_chk(RA[7:0] + 8'h01, 2);
    run(mk(OP_CLAST, RA, 12'h000, 12'h002));
    bytes_chk(RA[7:0] + 8'h02, 2);
    run(mk(OP_COLRD, RA, 12'h040, 12'h002));
    bytes_chk(8'h42 + RA[7:0], 2);
    run(mk(OP_CPYRD, RA, 12'h010, 12'h001));
    bytes_chk(8'h10 + RA[7:0], 1);
  endtask : t_read
  // Same-district pair is refused; a proper pair leaves the second group's row latched
  task automatic t_multi();
    r = mk(OP_MREAD, {11'h004, 6'h09}, 12'h000, 12'h000);
    r.addr_b = {12'h000, 6'h09, 11'h006};
    run(r);
    chk(e, 1'b1);
    r.addr_b.block = 11'h007;
    run(r);
    chk({e, fm_u.row}, {1'b0, 11'h007, 6'h09});
    run(mk(OP_RESET, 17'h00000, 12'h000, 12'h000));
    chk(fm_u.cmd, 8'hff);
  endtask : t_multi
  // Fill the FIFO until it refuses, then program one page
  task automatic t_prog(input logic pe);
    int k, s0, n0;
    {k, s0, n0} = {32'd0, fm_u.sum, fm_u.n_prog};
    @(posedge clock);
    prog_enable <= pe;
    wr_valid <= 1'b1;
    repeat (20) begin
      @(negedge clock);
      if (wr_ready !== 1'b1) break;
      @(posedge clock);
      s0 += wr_data;
      k++;
      wr_data <= wr_data + 8'h07;
    end
    @(posedge clock) wr_valid <= 1'b0;
    chk(k, 16);
    // First half without confirm, second half after a column change
    r = mk(OP_PROG, {11'h013, 6'h02}, 12'h000, 12'h008);
    r.last = 1'b0;
    run(r);
    chk(fm_u.n_prog, n0);
    run(mk(OP_COLWR, {11'h013, 6'h02}, 12'h321, 12'h008));
    chk(fm_u.col, 12'h321);
    chk(fm_u.n_prog - n0, pe);
    if (pe) chk(fm_u.sum, s0);
  endtask : t_prog
  // Status byte carries lock and ready
  task automatic t_status(input nfc_op_t o, input logic pe);
    @(posedge clock);
    prog_enable <= pe;
    run(mk(o, 17'h00000, 12'h000, 12'h001));
    bytes_chk({pe, 7'h60}, 1);
  endtask : t_status
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    t_read();
    t_multi();
    fm_u.busy_ns = 6000;
    t_prog(1'b1);
    t_status(OP_STATUS, 1'b1);
    t_status(OP_STATUS_MP, 1'b0);
    t_prog(1'b0);
    finish_test();
  end
endmodule : nfc_host_bench
